//--- lpm_pkg.sv
// constants and state codes shared by the low-power and emulation mode sequencer
// assumes one 250 MHz clock that stands for the oscillator input, sync active-high reset
`default_nettype none

package lpm_pkg;

    // ----------------------------------------
    // timing
    // ----------------------------------------
    localparam logic [2:0] LPM_LAST_PHASE = 3'h5;
    localparam logic [1:0] LPM_RST_MC = 2'h2;

    // ----------------------------------------
    // sequencer states
    // ----------------------------------------
    typedef enum logic [2:0] {
        LPM_ST_RUN = 3'b000,
        LPM_ST_IDLE = 3'b001,
        LPM_ST_IDLE_RST = 3'b010,
        LPM_ST_PDOWN = 3'b011,
        LPM_ST_PD_RST = 3'b100,
        LPM_ST_PD_IRQ = 3'b101,
        LPM_ST_RESET = 3'b110,
        LPM_ST_ONCE = 3'b111
    } lpm_state_t;

    localparam lpm_state_t LPM_ST_RST_VAL = LPM_ST_RESET;

endpackage : lpm_pkg

`default_nettype wire

//--- lpm_clk_div.sv
// divide-by-two stage and machine-cycle enable generator
// assumes i_osc_en is a registered gate; counts stop while it is low
`default_nettype none

module lpm_clk_div
    import lpm_pkg::*;
(
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst,
    // oscillator gate
    input wire logic i_osc_en,
    // enables
    output logic o_phase_en,
    output logic o_mc_en
);

    typedef struct packed {
        logic div;
        logic [2:0] phase;
        logic phase_en;
        logic mc_en;
    } lpm_div_t;

    lpm_div_t r_q;
    lpm_div_t r_d;

    always_comb begin
        r_d = r_q;
        r_d.phase_en = 1'b0;
        r_d.mc_en = 1'b0;
        if (i_osc_en) begin
            // any input duty cycle is fine: only every second edge counts
            r_d.div = ~r_q.div;
            if (r_q.div) begin
                r_d.phase_en = 1'b1;
                if (r_q.phase == LPM_LAST_PHASE) begin
                    r_d.phase = 3'h0;
                    r_d.mc_en = 1'b1;
                end else begin
                    r_d.phase = r_q.phase + 3'h1;
                end
            end
        end
        if (i_rst) begin
            r_d = '0;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        r_q <= r_d;
    end

    assign o_phase_en = r_q.phase_en;
    assign o_mc_en = r_q.mc_en;

    a_phase_half_rate: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        r_q.phase_en |=> !r_q.phase_en)
        else $error("phase enable faster than half the oscillator rate");

endmodule : lpm_clk_div

`default_nettype wire

//--- lpm_seq.sv
// idle, power-down, reset and emulation mode sequencer
// assumes the core gives an instruction-end pulse and the enabled pending interrupt level
`default_nettype none

module lpm_seq
    import lpm_pkg::*;
(
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst,
    // pins
    input wire logic i_reset_pin,
    input wire logic i_ext_irq_zero_pin,
    input wire logic i_ext_irq_one_pin,
    input wire logic i_addr_latch_strobe_pin,
    input wire logic i_program_fetch_strobe_pin,
    // core
    input wire logic i_instr_end,
    input wire logic i_idle_req,
    input wire logic i_pdown_req,
    input wire logic i_irq_pending,
    input wire logic i_irq_zero_en,
    input wire logic i_irq_one_en,
    input wire logic i_irq_zero_level,
    input wire logic i_irq_one_level,
    input wire logic i_ext_mem,
    input wire logic i_core_ale,
    input wire logic i_core_program_fetch_strobe,
    // strobe pins
    output logic o_addr_latch_strobe,
    output logic o_addr_latch_strobe_oe,
    output logic o_addr_latch_strobe_weak,
    output logic o_program_fetch_strobe,
    output logic o_program_fetch_strobe_oe,
    output logic o_program_fetch_strobe_weak,
    // port control
    output logic o_p0_float,
    output logic o_p2_addr,
    output logic o_ports_hold,
    output logic o_ports_weak,
    // core control
    output logic o_osc_en,
    output logic o_cpu_run,
    output logic o_ram_block,
    output logic o_sfr_reset,
    output logic o_irq_wake,
    output logic o_phase_en,
    output logic [2:0] o_mode
);

    typedef struct packed {
        lpm_state_t st;
        logic [1:0] rcnt;
        logic once_arm;
        logic osc_en;
        logic ale;
        logic ale_oe;
        logic ale_weak;
        logic program_fetch_strobe;
        logic program_fetch_strobe_oe;
        logic program_fetch_strobe_weak;
        logic p0_float;
        logic p2_addr;
        logic ports_hold;
        logic ports_weak;
        logic cpu_run;
        logic ram_block;
        logic sfr_reset;
        logic irq_wake;
    } lpm_seq_t;

    lpm_seq_t r_q;
    lpm_seq_t r_d;
    logic mc_en;
    logic rst_rec;
    logic irq_act;

    // ----------------------------------------
    // machine-cycle timing
    // ----------------------------------------
    lpm_clk_div lpm_clk_div_inst (
        .i_sys_clk(i_sys_clk),
        .i_rst(i_rst),
        .i_osc_en(r_q.osc_en),
        .o_phase_en(o_phase_en),
        .o_mc_en(mc_en)
    );

    assign rst_rec = (r_q.rcnt == LPM_RST_MC);
    // only enabled level-sensitive pins held low wake power-down
    assign irq_act = (i_irq_zero_en & i_irq_zero_level & ~i_ext_irq_zero_pin)
                   | (i_irq_one_en & i_irq_one_level & ~i_ext_irq_one_pin);

    // ----------------------------------------
    // sequencer
    // ----------------------------------------
    always_comb begin
        r_d = r_q;
        // reset counts machine cycles only while the oscillator runs
        if (!i_reset_pin) begin
            r_d.rcnt = 2'h0;
        end else if (mc_en && !rst_rec) begin
            r_d.rcnt = r_q.rcnt + 2'h1;
        end
        r_d.irq_wake = 1'b0;
        unique case (r_q.st)
            LPM_ST_RUN: begin
                if (rst_rec) begin
                    r_d.st = LPM_ST_RESET;
                end else if (i_instr_end && i_pdown_req) begin
                    r_d.st = LPM_ST_PDOWN;
                end else if (i_instr_end && i_idle_req) begin
                    r_d.st = LPM_ST_IDLE;
                end
            end
            LPM_ST_IDLE: begin
                if (i_reset_pin) begin
                    r_d.st = LPM_ST_IDLE_RST;
                end else if (i_irq_pending) begin
                    r_d.st = LPM_ST_RUN;
                    r_d.irq_wake = 1'b1;
                end
            end
            LPM_ST_IDLE_RST: begin
                // core runs on until the internal reset takes over
                if (rst_rec) begin
                    r_d.st = LPM_ST_RESET;
                end else if (!i_reset_pin) begin
                    r_d.st = LPM_ST_RUN;
                end
            end
            LPM_ST_PDOWN: begin
                if (i_reset_pin) begin
                    r_d.st = LPM_ST_PD_RST;
                end else if (irq_act) begin
                    r_d.st = LPM_ST_PD_IRQ;
                end
            end
            LPM_ST_PD_RST: begin
                if (rst_rec) begin
                    r_d.st = LPM_ST_RESET;
                end else if (!i_reset_pin) begin
                    r_d.st = LPM_ST_PDOWN;
                end
            end
            LPM_ST_PD_IRQ: begin
                if (rst_rec) begin
                    r_d.st = LPM_ST_RESET;
                end else if (!irq_act) begin
                    // no register reset: execution resumes after the power-down instruction
                    r_d.st = LPM_ST_RUN;
                    r_d.irq_wake = 1'b1;
                end
            end
            LPM_ST_RESET: begin
                if (!i_addr_latch_strobe_pin && i_program_fetch_strobe_pin) begin
                    r_d.once_arm = 1'b1;
                end
                if (!i_reset_pin) begin
                    r_d.st = (r_q.once_arm && !i_addr_latch_strobe_pin) ? LPM_ST_ONCE : LPM_ST_RUN;
                    r_d.once_arm = 1'b0;
                end
            end
            LPM_ST_ONCE: begin
                if (rst_rec) begin
                    r_d.st = LPM_ST_RESET;
                end
            end
        endcase

        // ----------------------------------------
        // pin and core controls of the next state
        // ----------------------------------------
        r_d.osc_en = (r_d.st != LPM_ST_PDOWN);
        r_d.ale = i_core_ale;
        r_d.program_fetch_strobe = i_core_program_fetch_strobe;
        r_d.ale_oe = 1'b1;
        r_d.program_fetch_strobe_oe = 1'b1;
        r_d.ale_weak = 1'b0;
        r_d.program_fetch_strobe_weak = 1'b0;
        r_d.p0_float = 1'b0;
        r_d.p2_addr = 1'b0;
        r_d.ports_hold = 1'b0;
        r_d.ports_weak = 1'b0;
        r_d.cpu_run = 1'b0;
        r_d.ram_block = 1'b0;
        r_d.sfr_reset = 1'b0;
        unique case (r_d.st)
            LPM_ST_RUN: begin
                r_d.cpu_run = 1'b1;
            end
            LPM_ST_IDLE: begin
                r_d.ale = 1'b1;
                r_d.program_fetch_strobe = 1'b1;
                r_d.p0_float = i_ext_mem;
                r_d.p2_addr = i_ext_mem;
                r_d.ports_hold = 1'b1;
            end
            LPM_ST_IDLE_RST: begin
                r_d.cpu_run = 1'b1;
                r_d.ram_block = 1'b1;
            end
            LPM_ST_PDOWN, LPM_ST_PD_RST, LPM_ST_PD_IRQ: begin
                r_d.ale = 1'b0;
                r_d.program_fetch_strobe = 1'b0;
                r_d.p0_float = i_ext_mem;
                r_d.ports_hold = 1'b1;
            end
            LPM_ST_RESET: begin
                // strobes released so the board can strap emulation entry
                r_d.ale_oe = 1'b0;
                r_d.program_fetch_strobe_oe = 1'b0;
                r_d.ale_weak = 1'b1;
                r_d.program_fetch_strobe_weak = 1'b1;
                r_d.ram_block = 1'b1;
                r_d.sfr_reset = 1'b1;
            end
            LPM_ST_ONCE: begin
                r_d.ale_oe = 1'b0;
                r_d.program_fetch_strobe_oe = 1'b0;
                r_d.ale_weak = 1'b1;
                r_d.program_fetch_strobe_weak = 1'b1;
                r_d.p0_float = 1'b1;
                r_d.ports_weak = 1'b1;
            end
        endcase
        if (i_rst) begin
            r_d = '0;
            r_d.st = LPM_ST_RST_VAL;
            r_d.osc_en = 1'b1;
            r_d.ale_weak = 1'b1;
            r_d.program_fetch_strobe_weak = 1'b1;
            r_d.ram_block = 1'b1;
            r_d.sfr_reset = 1'b1;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        r_q <= r_d;
    end

    assign o_addr_latch_strobe = r_q.ale;
    assign o_addr_latch_strobe_oe = r_q.ale_oe;
    assign o_addr_latch_strobe_weak = r_q.ale_weak;
    assign o_program_fetch_strobe = r_q.program_fetch_strobe;
    assign o_program_fetch_strobe_oe = r_q.program_fetch_strobe_oe;
    assign o_program_fetch_strobe_weak = r_q.program_fetch_strobe_weak;
    assign o_p0_float = r_q.p0_float;
    assign o_p2_addr = r_q.p2_addr;
    assign o_ports_hold = r_q.ports_hold;
    assign o_ports_weak = r_q.ports_weak;
    assign o_osc_en = r_q.osc_en;
    assign o_cpu_run = r_q.cpu_run;
    assign o_ram_block = r_q.ram_block;
    assign o_sfr_reset = r_q.sfr_reset;
    assign o_irq_wake = r_q.irq_wake;
    assign o_mode = r_q.st;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    localparam int MC_TWO_MAX = 26;

    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_rst);

    a_idle_no_exec: assert property ((r_q.st == LPM_ST_IDLE) |-> !o_cpu_run && !o_sfr_reset)
        else $error("core runs or resets during idle");
    a_idle_irq_exit: assert property ((r_q.st == LPM_ST_IDLE) && i_irq_pending && !i_reset_pin
        |=> (r_q.st == LPM_ST_RUN) && o_irq_wake && o_cpu_run)
        else $error("idle not left on pending interrupt");
    a_idle_pins: assert property ((r_q.st == LPM_ST_IDLE) |-> o_addr_latch_strobe && o_program_fetch_strobe
        && (o_p0_float == $past(i_ext_mem)) && (o_p2_addr == $past(i_ext_mem)))
        else $error("idle pin states wrong");
    a_pd_pins: assert property ((r_q.st == LPM_ST_PDOWN) |-> !o_addr_latch_strobe && !o_program_fetch_strobe
        && !o_p2_addr && (o_p0_float == $past(i_ext_mem)))
        else $error("power-down pin states wrong");
    a_pd_osc_stop: assert property ((r_q.st == LPM_ST_RUN) && i_instr_end && i_pdown_req && !rst_rec
        |=> !o_osc_en && !o_cpu_run)
        else $error("oscillator not stopped on power-down");
    a_pd_priority: assert property ((r_q.st == LPM_ST_RUN) && i_instr_end && i_pdown_req && i_idle_req
        && !rst_rec |=> (r_q.st == LPM_ST_PDOWN))
        else $error("idle taken over power-down");
    a_pd_irq_wake: assert property ((r_q.st == LPM_ST_PD_IRQ) && !irq_act && !rst_rec
        |=> (r_q.st == LPM_ST_RUN) && o_irq_wake && !o_sfr_reset && o_osc_en)
        else $error("interrupt wake not completed");
    a_idle_rst_ram: assert property ((r_q.st == LPM_ST_IDLE_RST) |-> o_ram_block && o_cpu_run)
        else $error("RAM not blocked while idle ends by reset");
    a_idle_rst_bound: assert property ($rose(r_q.st == LPM_ST_IDLE_RST)
        |-> ##[1:MC_TWO_MAX] (r_q.st != LPM_ST_IDLE_RST))
        else $error("idle reset window exceeds two machine cycles");
    // the pin may drop in the very cycle the count completes, so look one cycle further back
    a_reset_filter: assert property ($rose(o_sfr_reset) |-> $past(i_reset_pin, 2) && $past(i_reset_pin, 14))
        else $error("reset recognised too early");
    a_once_pins: assert property ((r_q.st == LPM_ST_ONCE) |-> o_p0_float && o_ports_weak && o_osc_en
        && !o_addr_latch_strobe_oe && o_addr_latch_strobe_weak && o_program_fetch_strobe_weak)
        else $error("emulation pin states wrong");
    a_once_sticky: assert property ((r_q.st == LPM_ST_ONCE) && !rst_rec |=> (r_q.st == LPM_ST_ONCE))
        else $error("emulation left without reset");

    c_once_entry: cover property ((r_q.st == LPM_ST_RESET) ##1 (r_q.st == LPM_ST_ONCE));
    c_pd_irq_wake: cover property ((r_q.st == LPM_ST_PD_IRQ) ##1 (r_q.st == LPM_ST_RUN));
    c_idle_reset: cover property ((r_q.st == LPM_ST_IDLE_RST) ##1 (r_q.st == LPM_ST_RESET));

endmodule : lpm_seq

`default_nettype wire

//--- lpm_board.sv
// board model: reset pin, external interrupt pins and emulation strap
// assumes the bench changes pins just after a rising clock edge
`default_nettype none

module lpm_board (
    // strobes from the device
    input wire logic i_ale,
    input wire logic i_ale_oe,
    input wire logic i_ale_weak,
    input wire logic i_program_fetch_strobe,
    input wire logic i_program_fetch_strobe_oe,
    input wire logic i_program_fetch_strobe_weak,
    // pins to the device
    output logic o_reset_pin,
    output logic o_irq_zero_n,
    output logic o_irq_one_n,
    output logic o_ale_pin,
    output logic o_program_fetch_strobe_pin
);
    timeunit 1ns;
    timeprecision 100ps;

    logic strap_q;

    // power-on: reset held high until the bench lets go
    initial begin
        o_reset_pin = 1'b1;
        o_irq_zero_n = 1'b1;
        o_irq_one_n = 1'b1;
        strap_q = 1'b0;
    end

    // strap pulls the latch strobe low; a pin neither driven nor pulled reads low
    assign o_ale_pin = strap_q ? 1'b0 : (i_ale_oe ? i_ale : i_ale_weak);
    assign o_program_fetch_strobe_pin = i_program_fetch_strobe_oe ? i_program_fetch_strobe : i_program_fetch_strobe_weak;

    // levels stay until changed, so wake sources are held as long as the bench wants
    task automatic set_pins(input logic rst, input logic irq0_n, input logic irq1_n, input logic strap);
        o_reset_pin = rst;
        o_irq_zero_n = irq0_n;
        o_irq_one_n = irq1_n;
        strap_q = strap;
    endtask : set_pins
endmodule : lpm_board

`default_nettype wire

//--- low_power_and_emulation_modes_tb.sv
// self-checking bench for the idle, power-down, reset and emulation sequencer
// assumes lpm_pkg, lpm_seq and lpm_board are compiled first; 250 MHz clock
`default_nettype none

module low_power_and_emulation_modes_tb import lpm_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;

    int failures = 0;
    int checks = 0;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic instr_end = 1'b0;
    logic idle_req = 1'b0;
    logic pdown_req = 1'b0;
    logic irq_pending = 1'b0;
    logic irq_zero_en = 1'b0;
    logic irq_zero_level = 1'b0;
    logic ext_mem = 1'b0;
    logic irq_one_en = 1'b0;
    logic irq_one_level = 1'b0;
    logic core_ale = 1'b1;
    logic core_program_fetch_strobe = 1'b1;
    logic reset_pin, irq_zero_n, irq_one_n, ale_pin, program_fetch_strobe_pin;
    logic ale, ale_oe, ale_weak, program_fetch_strobe, program_fetch_strobe_oe, program_fetch_strobe_weak;
    logic p0_float, p2_addr, ports_hold, ports_weak, osc_en, cpu_run;
    logic ram_block, sfr_reset, irq_wake, phase_en;
    logic [2:0] mode;

    always #2 sys_clk = ~sys_clk;

    lpm_seq lpm_seq_inst (
        .i_sys_clk(sys_clk), .i_rst(rst), .i_reset_pin(reset_pin),
        .i_ext_irq_zero_pin(irq_zero_n), .i_ext_irq_one_pin(irq_one_n),
        .i_addr_latch_strobe_pin(ale_pin), .i_program_fetch_strobe_pin(program_fetch_strobe_pin),
        .i_instr_end(instr_end), .i_idle_req(idle_req), .i_pdown_req(pdown_req),
        .i_irq_pending(irq_pending), .i_irq_zero_en(irq_zero_en), .i_irq_one_en(irq_one_en),
        .i_irq_zero_level(irq_zero_level), .i_irq_one_level(irq_one_level), .i_ext_mem(ext_mem),
        .i_core_ale(core_ale), .i_core_program_fetch_strobe(core_program_fetch_strobe),
        .o_addr_latch_strobe(ale), .o_addr_latch_strobe_oe(ale_oe), .o_addr_latch_strobe_weak(ale_weak),
        .o_program_fetch_strobe(program_fetch_strobe), .o_program_fetch_strobe_oe(program_fetch_strobe_oe),
        .o_program_fetch_strobe_weak(program_fetch_strobe_weak), .o_p0_float(p0_float), .o_p2_addr(p2_addr),
        .o_ports_hold(ports_hold), .o_ports_weak(ports_weak), .o_osc_en(osc_en), .o_cpu_run(cpu_run),
        .o_ram_block(ram_block), .o_sfr_reset(sfr_reset), .o_irq_wake(irq_wake),
        .o_phase_en(phase_en), .o_mode(mode)
    );

    lpm_board lpm_board_inst (
        .i_ale(ale), .i_ale_oe(ale_oe), .i_ale_weak(ale_weak),
        .i_program_fetch_strobe(program_fetch_strobe), .i_program_fetch_strobe_oe(program_fetch_strobe_oe), .i_program_fetch_strobe_weak(program_fetch_strobe_weak),
        .o_reset_pin(reset_pin), .o_irq_zero_n(irq_zero_n), .o_irq_one_n(irq_one_n),
        .o_ale_pin(ale_pin), .o_program_fetch_strobe_pin(program_fetch_strobe_pin)
    );

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic report_and_stop();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : report_and_stop

    task automatic step(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : step

    task automatic chk_bit(input string name, input logic exp, input logic got);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("FAIL %s expected %b seen %b", name, exp, got);
        end
    endtask : chk_bit

    task automatic chk_mode(input string name, input logic [2:0] exp, input logic [2:0] got);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("FAIL %s expected %h seen %h", name, exp, got);
        end
    endtask : chk_mode

    // bounded wait; running out ends the run
    task automatic wait_mode(input logic [2:0] exp, input int bound);
        int n;
        n = 0;
        while (mode !== exp && n < bound) begin
            step(1);
            n++;
        end
        chk_mode("mode", exp, mode);
        if (mode !== exp) report_and_stop();
    endtask : wait_mode

    task automatic req(input logic idle, input logic pdown);
        idle_req = idle;
        pdown_req = pdown;
        instr_end = 1'b1;
        step(1);
        instr_end = 1'b0;
        idle_req = 1'b0;
        pdown_req = 1'b0;
    endtask : req

    task automatic pins(input logic r, input logic i0, input logic s);
        lpm_board_inst.set_pins(r, i0, 1'b1, s);
    endtask : pins

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_reset_run();
        int pulses;
        pulses = 0;
        step(3);
        chk_mode("reset mode", LPM_ST_RESET, mode);
        chk_bit("sfr reset", 1'b1, sfr_reset);
        chk_bit("ale oe", 1'b0, ale_oe);
        rst = 1'b0;
        step(2);
        chk_mode("held reset", LPM_ST_RESET, mode);
        pins(1'b0, 1'b1, 1'b0);
        wait_mode(LPM_ST_RUN, 3);
        repeat (12) begin
            step(1);
            pulses += int'(phase_en === 1'b1);
        end
        chk_bit("phase rate", 1'b1, pulses == 6);
        $display("test reset_run done");
    endtask : t_reset_run

    task automatic t_idle_wake();
        ext_mem = 1'b1;
        // core strobes low so the forced idle levels can be told apart
        core_ale = 1'b0;
        core_program_fetch_strobe = 1'b0;
        req(1'b1, 1'b0);
        wait_mode(LPM_ST_IDLE, 2);
        chk_bit("cpu run", 1'b0, cpu_run);
        chk_bit("ale", 1'b1, ale);
        chk_bit("program_fetch_strobe", 1'b1, program_fetch_strobe);
        chk_bit("p0 float", 1'b1, p0_float);
        chk_bit("p2 addr", 1'b1, p2_addr);
        chk_bit("hold", 1'b1, ports_hold);
        step(1);
        req(1'b0, 1'b1);
        step(2);
        chk_mode("ignored req", LPM_ST_IDLE, mode);
        irq_pending = 1'b1;
        step(1);
        chk_mode("woken", LPM_ST_RUN, mode);
        chk_bit("wake pulse", 1'b1, irq_wake);
        chk_bit("ale run", 1'b0, ale);
        irq_pending = 1'b0;
        core_ale = 1'b1;
        core_program_fetch_strobe = 1'b1;
        step(1);
        chk_bit("wake pulse end", 1'b0, irq_wake);
        $display("test idle_wake done");
    endtask : t_idle_wake

    task automatic t_pdown_irq();
        irq_zero_en = 1'b1;
        req(1'b1, 1'b1);
        wait_mode(LPM_ST_PDOWN, 2);
        step(1);
        chk_bit("osc", 1'b0, osc_en);
        chk_bit("phase", 1'b0, phase_en);
        chk_bit("ale", 1'b0, ale);
        chk_bit("program_fetch_strobe", 1'b0, program_fetch_strobe);
        chk_bit("p0 float", 1'b1, p0_float);
        chk_bit("p2 addr", 1'b0, p2_addr);
        pins(1'b0, 1'b0, 1'b0);
        step(4);
        chk_mode("edge irq", LPM_ST_PDOWN, mode);
        irq_zero_level = 1'b1;
        wait_mode(LPM_ST_PD_IRQ, 2);
        chk_bit("osc back", 1'b1, osc_en);
        step(10);
        pins(1'b0, 1'b1, 1'b0);
        wait_mode(LPM_ST_RUN, 2);
        chk_bit("wake pulse", 1'b1, irq_wake);
        chk_bit("no sfr reset", 1'b0, sfr_reset);
        chk_bit("cpu run", 1'b1, cpu_run);
        // second wake through the other interrupt pin
        irq_zero_en = 1'b0;
        irq_one_en = 1'b1;
        req(1'b0, 1'b1);
        wait_mode(LPM_ST_PDOWN, 2);
        lpm_board_inst.set_pins(1'b0, 1'b1, 1'b0, 1'b0);
        step(2);
        chk_mode("edge irq one", LPM_ST_PDOWN, mode);
        irq_one_level = 1'b1;
        wait_mode(LPM_ST_PD_IRQ, 2);
        pins(1'b0, 1'b1, 1'b0);
        wait_mode(LPM_ST_RUN, 2);
        chk_bit("wake pulse one", 1'b1, irq_wake);
        $display("test pdown_irq done");
    endtask : t_pdown_irq

    task automatic t_idle_reset();
        // no port or external write follows the idle request here
        req(1'b1, 1'b0);
        wait_mode(LPM_ST_IDLE, 2);
        pins(1'b1, 1'b1, 1'b0);
        step(1);
        pins(1'b0, 1'b1, 1'b0);
        wait_mode(LPM_ST_IDLE_RST, 2);
        chk_bit("ram block", 1'b1, ram_block);
        chk_bit("cpu run", 1'b1, cpu_run);
        wait_mode(LPM_ST_RUN, 30);
        req(1'b1, 1'b0);
        wait_mode(LPM_ST_IDLE, 2);
        pins(1'b1, 1'b1, 1'b0);
        wait_mode(LPM_ST_IDLE_RST, 2);
        wait_mode(LPM_ST_RESET, 26);
        pins(1'b0, 1'b1, 1'b0);
        wait_mode(LPM_ST_RUN, 3);
        $display("test idle_reset done");
    endtask : t_idle_reset

    task automatic t_pdown_reset_emul();
        req(1'b0, 1'b1);
        wait_mode(LPM_ST_PDOWN, 2);
        pins(1'b1, 1'b1, 1'b0);
        wait_mode(LPM_ST_PD_RST, 2);
        chk_bit("osc", 1'b1, osc_en);
        wait_mode(LPM_ST_RESET, 26);
        chk_bit("sfr reset", 1'b1, sfr_reset);
        pins(1'b1, 1'b1, 1'b1);
        step(2);
        pins(1'b0, 1'b1, 1'b1);
        wait_mode(LPM_ST_ONCE, 3);
        pins(1'b0, 1'b1, 1'b0);
        step(1);
        chk_bit("p0 float", 1'b1, p0_float);
        chk_bit("ports weak", 1'b1, ports_weak);
        chk_bit("ale weak", 1'b1, ale_weak);
        chk_bit("program_fetch_strobe weak", 1'b1, program_fetch_strobe_weak);
        chk_bit("ale oe", 1'b0, ale_oe);
        chk_bit("program_fetch_strobe oe", 1'b0, program_fetch_strobe_oe);
        chk_bit("osc", 1'b1, osc_en);
        pins(1'b1, 1'b1, 1'b0);
        step(2);
        pins(1'b0, 1'b1, 1'b0);
        step(30);
        chk_mode("short reset", LPM_ST_ONCE, mode);
        pins(1'b1, 1'b1, 1'b0);
        wait_mode(LPM_ST_RESET, 30);
        pins(1'b0, 1'b1, 1'b0);
        wait_mode(LPM_ST_RUN, 3);
        $display("test pdown_reset_emul done");
    endtask : t_pdown_reset_emul

    initial begin
        t_reset_run();
        t_idle_wake();
        t_pdown_irq();
        t_idle_reset();
        t_pdown_reset_emul();
        report_and_stop();
    end
endmodule : low_power_and_emulation_modes_tb

`default_nettype wire
